// ### hw/rx_link_status_pkg.sv
package rx_link_status_pkg;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] ADDR_GENERAL_CONFIG = 8'h02;
   localparam logic [7:0] ADDR_PORT_CAPABILITY = 8'h4A;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h4B;
   localparam logic [7:0] ADDR_PARITY_THRESHOLD = 8'h4C;
   localparam logic [7:0] ADDR_PORT_STATUS_ONE = 8'h4D;
   localparam logic [7:0] ADDR_PORT_STATUS_TWO = 8'h4E;
   localparam logic [7:0] ADDR_SENSOR_STATUS_A = 8'h51;
   localparam logic [7:0] ADDR_SENSOR_STATUS_B = 8'h52;
   localparam logic [7:0] ADDR_SENSOR_STATUS_C = 8'h53;
   localparam logic [7:0] ADDR_SENSOR_STATUS_D = 8'h54;
   localparam logic [7:0] ADDR_PARITY_COUNT_HIGH = 8'h55;
   localparam logic [7:0] ADDR_PARITY_COUNT_LOW = 8'h56;
   localparam logic [7:0] ADDR_LINES_HIGH = 8'h73;
   localparam logic [7:0] ADDR_LINES_LOW = 8'h74;
   localparam logic [7:0] ADDR_LINE_BYTES_HIGH = 8'h75;
   localparam logic [7:0] ADDR_LINE_BYTES_LOW = 8'h76;
   localparam logic [7:0] ADDR_FREQ_DETECT_CONTROL = 8'h77;
   localparam logic [7:0] ADDR_FREQ_VALUE_HIGH = 8'h78;
   localparam logic [7:0] ADDR_FREQ_VALUE_LOW = 8'h79;
   localparam logic [7:0] ADDR_ENCODER_CRC_CONTROL = 8'hBA;
   localparam logic [7:0] ADDR_SENSOR_RISE_IRQ = 8'hDE;
   localparam logic [7:0] ADDR_SENSOR_FALL_IRQ = 8'hDF;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int GEN_PARITY_ENABLE_BIT = 0;
   localparam int GEN_RAW_MODE_BIT = 1;
   localparam int CAP_KEEP_PARITY_ON_UNLOCK_BIT = 0;
   localparam int CAP_ENCODER_CRC_CAPABLE_BIT = 4;
   localparam int CRC_DISABLE_BIT = 7;
   localparam int STS1_LOCKED_BIT = 0;
   localparam int STS1_LOCK_CHANGE_BIT = 1;
   localparam int STS1_PARITY_BIT = 2;
   localparam int STS1_CC_CRC_BIT = 4;
   localparam int STS1_CC_SEQ_BIT = 5;
   localparam int STS2_FREQ_STABLE_BIT = 1;
   localparam int STS2_CABLE_FAULT_BIT = 2;
   localparam int STS2_FREQ_CHANGE_BIT = 3;
   localparam int STS2_ENCODER_ERR_BIT = 5;
   localparam int STS2_LINES_CHANGE_BIT = 6;
   localparam int STS2_LENGTH_CHANGE_BIT = 7;
   localparam int IRQ_PARITY_BIT = 0;
   localparam int IRQ_ENCODER_BIT = 1;
   localparam int IRQ_FREQ_BIT = 2;
   localparam int IRQ_LINES_BIT = 3;
   localparam int IRQ_LENGTH_BIT = 4;
   localparam int IRQ_SENSOR_BIT = 5;

   // ****************************************
   // Reset values and timing
   // ****************************************
   localparam logic [7:0] GENERAL_CONFIG_RESET = 8'h01;
   localparam logic [7:0] ENCODER_CRC_CONTROL_RESET = 8'h80;
   localparam logic [7:0] FREQ_DETECT_CONTROL_RESET = 8'h21;
   localparam logic [7:0] PARITY_THRESHOLD_RESET = 8'h01;
   localparam int CLK_PERIOD_PS = 10000;
   localparam int FREQ_WINDOW_NS = 1000;
   localparam int FREQ_WINDOW_CYCLES = (FREQ_WINDOW_NS * 1000) / CLK_PERIOD_PS;

endpackage : rx_link_status_pkg

// ### hw/rx_link_status_monitor.sv
module rx_link_status_monitor
   import rx_link_status_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   // Register port behind the serial control target
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   // Receiver pins (asynchronous)
   input wire logic port_locked_in,
   input wire logic link_clk_sense_in,
   // Decoder events (system clock)
   input wire logic parity_err_in,
   input wire logic encoder_code_err_in,
   input wire logic encoder_seq_err_in,
   input wire logic ctrl_channel_crc_err_in,
   input wire logic ctrl_channel_seq_err_in,
   // Link-information packets
   input wire logic info_valid_in,
   input wire logic info_crc_ok_in,
   input wire logic [31:0] info_sensor_in,
   // Video stream
   input wire logic long_packet_in,
   input wire logic [15:0] packet_bytes_in,
   input wire logic line_valid_in,
   input wire logic byte_valid_in,
   input wire logic frame_end_in,
   // Summary
   output logic port_locked_out,
   output logic irq_out
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [2:0] lock_sync;
      logic lock_filt;
      logic [2:0] clk_sync;
      logic clk_filt;
      logic [7:0] general_config;
      logic [7:0] capability;
      logic [7:0] irq_enable;
      logic [7:0] parity_threshold;
      logic [7:0] freq_control;
      logic [7:0] crc_control;
      logic lock_change;
      logic cc_crc_err;
      logic cc_seq_err;
      logic parity_flag;
      logic encoder_err;
      logic freq_change;
      logic lines_change;
      logic length_change;
      logic [15:0] parity_count;
      logic [7:0] parity_low_shadow;
      logic [3:0][7:0] sensor;
      logic [7:0] sensor_rise;
      logic [7:0] sensor_fall;
      logic [15:0] window_count;
      logic [15:0] edge_count;
      logic [15:0] freq_value;
      logic freq_stable;
      logic cable_fault;
      logic [15:0] line_count;
      logic [15:0] byte_count;
      logic [15:0] last_length;
      logic [15:0] lines_reg;
      logic [15:0] length_reg;
      logic line_valid_prev;
      logic [7:0] rdata;
   } state_s;

   state_s st;
   state_s next_st;

   function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
      abs_diff = (a > b) ? (a - b) : (b - a);
   endfunction : abs_diff

   function automatic logic rd_at(input logic rd, input logic [7:0] addr, input logic [7:0] a);
      rd_at = rd && (addr == a);
   endfunction : rd_at

   logic [7:0] status_one;
   logic [7:0] status_two;
   logic [7:0] rd_mux;
   logic lock_lost;
   logic raw_mode;
   logic line_end;
   logic [15:0] end_length;
   logic info_accept;
   logic [15:0] next_count;
   logic [7:0] rise_now;
   logic [7:0] fall_now;

   always_comb begin
      status_one = '0;
      status_one[STS1_LOCKED_BIT] = st.lock_filt;
      status_one[STS1_LOCK_CHANGE_BIT] = st.lock_change;
      status_one[STS1_PARITY_BIT] = st.parity_flag;
      status_one[STS1_CC_CRC_BIT] = st.cc_crc_err;
      status_one[STS1_CC_SEQ_BIT] = st.cc_seq_err;
      status_two = '0;
      status_two[STS2_FREQ_STABLE_BIT] = st.freq_stable;
      status_two[STS2_CABLE_FAULT_BIT] = st.cable_fault;
      status_two[STS2_FREQ_CHANGE_BIT] = st.freq_change;
      status_two[STS2_ENCODER_ERR_BIT] = st.encoder_err;
      status_two[STS2_LINES_CHANGE_BIT] = st.lines_change;
      status_two[STS2_LENGTH_CHANGE_BIT] = st.length_change;
      case (reg_addr_in)
         ADDR_GENERAL_CONFIG: rd_mux = st.general_config;
         ADDR_PORT_CAPABILITY: rd_mux = st.capability;
         ADDR_IRQ_ENABLE: rd_mux = st.irq_enable;
         ADDR_PARITY_THRESHOLD: rd_mux = st.parity_threshold;
         ADDR_PORT_STATUS_ONE: rd_mux = status_one;
         ADDR_PORT_STATUS_TWO: rd_mux = status_two;
         ADDR_SENSOR_STATUS_A: rd_mux = st.sensor[0];
         ADDR_SENSOR_STATUS_B: rd_mux = st.sensor[1];
         ADDR_SENSOR_STATUS_C: rd_mux = st.sensor[2];
         ADDR_SENSOR_STATUS_D: rd_mux = st.sensor[3];
         ADDR_PARITY_COUNT_HIGH: rd_mux = st.parity_count[15:8];
         ADDR_PARITY_COUNT_LOW: rd_mux = st.parity_low_shadow;
         ADDR_LINES_HIGH: rd_mux = st.lines_reg[15:8];
         ADDR_LINES_LOW: rd_mux = st.lines_reg[7:0];
         ADDR_LINE_BYTES_HIGH: rd_mux = st.length_reg[15:8];
         ADDR_LINE_BYTES_LOW: rd_mux = st.length_reg[7:0];
         ADDR_FREQ_DETECT_CONTROL: rd_mux = st.freq_control;
         ADDR_FREQ_VALUE_HIGH: rd_mux = st.freq_value[15:8];
         ADDR_FREQ_VALUE_LOW: rd_mux = st.freq_value[7:0];
         ADDR_ENCODER_CRC_CONTROL: rd_mux = st.crc_control;
         ADDR_SENSOR_RISE_IRQ: rd_mux = st.sensor_rise;
         ADDR_SENSOR_FALL_IRQ: rd_mux = st.sensor_fall;
         default: rd_mux = 8'h00;
      endcase
   end

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      next_st = st;
      lock_lost = 1'b0;
      raw_mode = st.general_config[GEN_RAW_MODE_BIT];
      line_end = 1'b0;
      end_length = st.last_length;
      info_accept = 1'b0;
      next_count = st.parity_count;
      rise_now = '0;
      fall_now = '0;

      if (reg_rd_in) begin
         next_st.rdata = rd_mux;
      end

      // Read-to-clear effects; every set below is applied afterwards so a new event wins, except a frame end held off by a pending enabled lines or length flag.
      if (rd_at(reg_rd_in, reg_addr_in, ADDR_PORT_STATUS_ONE)) begin
         next_st.lock_change = 1'b0;
         next_st.cc_crc_err = 1'b0;
         next_st.cc_seq_err = 1'b0;
      end
      if (rd_at(reg_rd_in, reg_addr_in, ADDR_PORT_STATUS_TWO)) begin
         next_st.encoder_err = 1'b0;
         next_st.freq_change = 1'b0;
      end
      if (rd_at(reg_rd_in, reg_addr_in, ADDR_LINES_LOW)) begin
         next_st.lines_change = 1'b0;
      end
      if (rd_at(reg_rd_in, reg_addr_in, ADDR_LINE_BYTES_LOW)) begin
         next_st.length_change = 1'b0;
      end
      if (rd_at(reg_rd_in, reg_addr_in, ADDR_SENSOR_RISE_IRQ)) begin
         next_st.sensor_rise = '0;
      end
      if (rd_at(reg_rd_in, reg_addr_in, ADDR_SENSOR_FALL_IRQ)) begin
         next_st.sensor_fall = '0;
      end

      if (reg_wr_in) begin
         case (reg_addr_in)
            ADDR_GENERAL_CONFIG: next_st.general_config = reg_wdata_in;
            ADDR_PORT_CAPABILITY: next_st.capability = reg_wdata_in;
            ADDR_IRQ_ENABLE: next_st.irq_enable = reg_wdata_in;
            ADDR_PARITY_THRESHOLD: next_st.parity_threshold = reg_wdata_in;
            ADDR_FREQ_DETECT_CONTROL: next_st.freq_control = reg_wdata_in;
            ADDR_ENCODER_CRC_CONTROL: next_st.crc_control = reg_wdata_in;
            default: next_st.rdata = next_st.rdata;
         endcase
      end

      // Lock: three-stage synchroniser, value taken once stages two and three agree.
      next_st.lock_sync = {st.lock_sync[1:0], port_locked_in};
      if (st.lock_sync[1] == st.lock_sync[2]) begin
         next_st.lock_filt = st.lock_sync[2];
      end
      if (next_st.lock_filt != st.lock_filt) begin
         next_st.lock_change = 1'b1;
         lock_lost = st.lock_filt;
      end
      if (ctrl_channel_crc_err_in) begin
         next_st.cc_crc_err = 1'b1;
      end
      if (ctrl_channel_seq_err_in) begin
         next_st.cc_seq_err = 1'b1;
      end

      // ****************************************
      // Parity counter
      // ****************************************
      if (rd_at(reg_rd_in, reg_addr_in, ADDR_PARITY_COUNT_HIGH)) begin
         // The low byte is snapshotted so the pair reads coherently after the clear.
         next_st.parity_low_shadow = st.parity_count[7:0];
         next_count = '0;
         next_st.parity_flag = 1'b0;
      end
      if (lock_lost && !st.capability[CAP_KEEP_PARITY_ON_UNLOCK_BIT]) begin
         next_count = '0;
         next_st.parity_flag = 1'b0;
      end
      if (parity_err_in && st.general_config[GEN_PARITY_ENABLE_BIT]
          && next_count != 16'hFFFF) begin
         next_count = next_count + 16'h0001;
      end
      next_st.parity_count = next_count;
      if (next_count >= {8'h00, st.parity_threshold} && next_count != 16'h0000) begin
         next_st.parity_flag = 1'b1;
      end

      if (encoder_code_err_in || encoder_seq_err_in) begin
         next_st.encoder_err = 1'b1;
      end

      // ****************************************
      // Link information and sensor status
      // ****************************************
      info_accept = info_valid_in && (info_crc_ok_in || st.crc_control[CRC_DISABLE_BIT]
                    || !st.capability[CAP_ENCODER_CRC_CAPABLE_BIT]);
      if (info_accept) begin
         next_st.sensor = info_sensor_in;
         rise_now = info_sensor_in[7:0] & ~st.sensor[0];
         fall_now = ~info_sensor_in[7:0] & st.sensor[0];
      end
      next_st.sensor_rise = next_st.sensor_rise | rise_now;
      next_st.sensor_fall = next_st.sensor_fall | fall_now;

      // ****************************************
      // Frequency detection
      // ****************************************
      next_st.clk_sync = {st.clk_sync[1:0], link_clk_sense_in};
      if (st.clk_sync[1] == st.clk_sync[2]) begin
         next_st.clk_filt = st.clk_sync[2];
      end
      if (next_st.clk_filt && !st.clk_filt) begin
         next_st.edge_count = st.edge_count + 16'h0001;
      end
      next_st.window_count = st.window_count + 16'h0001;
      if (st.window_count == 16'(FREQ_WINDOW_CYCLES - 1)) begin
         // One window of 1 us: edge count reads directly in MHz.
         next_st.window_count = '0;
         next_st.edge_count = '0;
         next_st.freq_value = st.edge_count;
         next_st.cable_fault = (st.edge_count == 16'h0000)
                               || (st.edge_count < {12'h000, st.freq_control[3:0]});
         if (abs_diff(st.edge_count, st.freq_value) > {12'h000, st.freq_control[7:4]}) begin
            next_st.freq_stable = 1'b0;
            next_st.freq_change = 1'b1;
         end else begin
            next_st.freq_stable = !next_st.cable_fault;
         end
      end

      // ****************************************
      // Line count and line length
      // ****************************************
      next_st.line_valid_prev = line_valid_in;
      if (raw_mode) begin
         if (line_valid_in && !st.line_valid_prev) begin
            next_st.line_count = st.line_count + 16'h0001;
            next_st.byte_count = '0;
         end else if (line_valid_in && byte_valid_in) begin
            next_st.byte_count = st.byte_count + 16'h0001;
         end
         line_end = !line_valid_in && st.line_valid_prev;
         end_length = st.byte_count;
      end else if (long_packet_in) begin
         next_st.line_count = st.line_count + 16'h0001;
         line_end = 1'b1;
         end_length = packet_bytes_in;
      end
      if (line_end) begin
         next_st.last_length = end_length;
      end
      if (frame_end_in) begin
         next_st.line_count = '0;
         if (!(st.lines_change && st.irq_enable[IRQ_LINES_BIT])) begin
            next_st.lines_reg = st.line_count;
            if (st.line_count != st.lines_reg) begin
               next_st.lines_change = 1'b1;
            end
         end
         if (!(st.length_change && st.irq_enable[IRQ_LENGTH_BIT])) begin
            next_st.length_reg = line_end ? end_length : st.last_length;
            if (next_st.length_reg != st.length_reg) begin
               next_st.length_change = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st <= '0;
         st.general_config <= GENERAL_CONFIG_RESET;
         st.crc_control <= ENCODER_CRC_CONTROL_RESET;
         st.freq_control <= FREQ_DETECT_CONTROL_RESET;
         st.parity_threshold <= PARITY_THRESHOLD_RESET;
      end else begin
         st <= next_st;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign reg_rdata_out = st.rdata;
   assign port_locked_out = st.lock_filt;
   assign irq_out = (st.irq_enable[IRQ_PARITY_BIT] && st.parity_flag)
                    || (st.irq_enable[IRQ_ENCODER_BIT] && st.encoder_err)
                    || (st.irq_enable[IRQ_FREQ_BIT] && st.freq_change)
                    || (st.irq_enable[IRQ_LINES_BIT] && st.lines_change)
                    || (st.irq_enable[IRQ_LENGTH_BIT] && st.length_change)
                    || (st.irq_enable[IRQ_SENSOR_BIT]
                        && ((st.sensor_rise | st.sensor_fall) != 8'h00));

endmodule : rx_link_status_monitor

// ### bench/rx_link_status_chk.sv
module rx_link_status_chk
   import rx_link_status_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   // Register port
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   // Lock and decoder events
   input wire logic port_locked_in,
   input wire logic parity_err_in,
   input wire logic encoder_code_err_in,
   input wire logic encoder_seq_err_in,
   input wire logic ctrl_channel_crc_err_in,
   input wire logic ctrl_channel_seq_err_in,
   input wire logic port_locked_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!resetn_in);
   logic rd_one;
   logic rd_two;
   logic rd_par;
   logic enc_any;
   assign rd_one = reg_rd_in && (reg_addr_in == ADDR_PORT_STATUS_ONE);
   assign rd_two = reg_rd_in && (reg_addr_in == ADDR_PORT_STATUS_TWO);
   assign rd_par = reg_rd_in && (reg_addr_in == ADDR_PARITY_COUNT_HIGH);
   assign enc_any = encoder_code_err_in || encoder_seq_err_in;
   chk_unmapped_zero: assert property (reg_rd_in && reg_addr_in == 8'hC0
      |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
   chk_rdata_holds: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
      else $error("read data moved without a read");
   chk_lock_rise: assert property (port_locked_in [*8] |-> port_locked_out)
      else $error("lock not reported");
   chk_lock_fall: assert property (!port_locked_in [*8] |-> !port_locked_out)
      else $error("lock loss not reported");
   chk_enc_sets: assert property (enc_any ##1 !rd_two ##1 rd_two |=> reg_rdata_out[5])
      else $error("encoder flag missing");
   chk_enc_clears: assert property ((rd_two && !enc_any) ##1 !enc_any
      ##1 (rd_two && !enc_any) |=> !reg_rdata_out[STS2_ENCODER_ERR_BIT])
      else $error("encoder flag not cleared");
   chk_crc_sets: assert property (ctrl_channel_crc_err_in ##1 !rd_one ##1 rd_one
      |=> reg_rdata_out[STS1_CC_CRC_BIT]) else $error("crc flag missing");
   chk_seq_sets: assert property (ctrl_channel_seq_err_in ##1 !rd_one ##1 rd_one
      |=> reg_rdata_out[STS1_CC_SEQ_BIT]) else $error("sequence flag missing");
   chk_parity_clears: assert property ((rd_par && !parity_err_in) ##1 !parity_err_in
      ##1 (rd_par && !parity_err_in) |=> reg_rdata_out == 8'h00)
      else $error("count not cleared");
   cover property ($rose(port_locked_out));
   cover property (rd_one ##1 reg_rdata_out[STS1_CC_CRC_BIT]);
   cover property (rd_par ##2 rd_par);
endmodule : rx_link_status_chk

bind rx_link_status_monitor rx_link_status_chk u_chk (.clk_sys_in(clk_sys_in),
   .resetn_in(resetn_in), .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out), .port_locked_in(port_locked_in),
   .parity_err_in(parity_err_in), .encoder_code_err_in(encoder_code_err_in),
   .encoder_seq_err_in(encoder_seq_err_in), .ctrl_channel_crc_err_in(ctrl_channel_crc_err_in),
   .ctrl_channel_seq_err_in(ctrl_channel_seq_err_in), .port_locked_out(port_locked_out));

// ### bench/remote_serializer_model.sv
module remote_serializer_model (
   // Clock and bench commands
   input wire logic clk_sys_in,
   input wire logic [2:0] cmd_in,
   input wire logic [31:0] arg_in,
   output logic done_out,
   // Link level, clock and events
   output logic locked_out,
   output logic sense_out,
   output logic [4:0] ev_out,
   // Link information and video
   output logic info_valid_out,
   output logic info_crc_ok_out,
   output logic [31:0] info_sensor_out,
   output logic long_packet_out,
   output logic [15:0] packet_bytes_out,
   output logic line_valid_out,
   output logic byte_valid_out,
   output logic frame_end_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic run = 1'b0;
   initial begin
      {locked_out, sense_out, ev_out, info_valid_out, info_crc_ok_out, done_out} = '0;
      {info_sensor_out, long_packet_out, packet_bytes_out} = '0;
      {line_valid_out, byte_valid_out, frame_end_out} = '0;
   end
   // The recovered clock stops low between bursts, as a dead cable would leave it.
   always begin
      #50;
      sense_out = run ? ~sense_out : 1'b0;
   end
   task automatic set_link(input logic lk, input logic on);
      @(negedge clk_sys_in);
      locked_out = lk;
      run = on;
   endtask : set_link
   task automatic pulse(input logic [4:0] m);
      @(negedge clk_sys_in);
      ev_out = m;
      @(negedge clk_sys_in);
      ev_out = 5'h00;
   endtask : pulse
   task automatic info(input logic [31:0] d, input logic ok);
      @(negedge clk_sys_in);
      info_sensor_out = d;
      info_crc_ok_out = ok;
      info_valid_out = 1'b1;
      @(negedge clk_sys_in);
      info_valid_out = 1'b0;
      info_sensor_out = ~d;
   endtask : info
   task automatic long_line(input logic [15:0] b);
      @(negedge clk_sys_in);
      long_packet_out = 1'b1;
      packet_bytes_out = b;
      @(negedge clk_sys_in);
      long_packet_out = 1'b0;
      packet_bytes_out = ~b;
   endtask : long_line
   task automatic raw_line(input int n);
      @(negedge clk_sys_in);
      line_valid_out = n != 0;
      repeat (n) begin
         @(negedge clk_sys_in);
         byte_valid_out = 1'b1;
         @(negedge clk_sys_in);
         byte_valid_out = 1'b0;
      end
      @(negedge clk_sys_in);
      line_valid_out = 1'b0;
      @(negedge clk_sys_in);
      frame_end_out = n == 0;
      @(negedge clk_sys_in);
      frame_end_out = 1'b0;
   endtask : raw_line
   always @(negedge clk_sys_in) begin
      if (done_out) begin
         done_out = 1'b0;
      end else if (cmd_in != 3'h0) begin
         case (cmd_in)
            3'h1: set_link(arg_in[0], arg_in[1]);
            3'h2: pulse(arg_in[4:0]);
            3'h3: info(arg_in, 1'b0);
            3'h4: info(arg_in, 1'b1);
            3'h5: long_line(arg_in[15:0]);
            default: raw_line(int'(arg_in));
         endcase
         done_out = 1'b1;
      end
   end
endmodule : remote_serializer_model

// ### bench/tb_top.sv
module tb_top
   import rx_link_status_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_in = 1'b0;
   logic resetn_in = 1'b0;
   logic [7:0] reg_addr_in = 8'h00;
   logic [7:0] reg_wdata_in = 8'h00;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic [7:0] reg_rdata_out;
   logic lk, sense, iv, iok, lp, lv, bv, fe, locked_o, irq_o;
   logic [4:0] ev;
   logic [31:0] isen;
   logic [15:0] pb;
   logic [2:0] far_cmd = 3'h0;
   logic [31:0] far_arg = 32'h0;
   logic far_done;
   int bad_count = 0;
   int tests_run = 0;
   int cycles = 0;
   remote_serializer_model u_remote_serializer_model (.clk_sys_in(clk_sys_in), .cmd_in(far_cmd),
      .arg_in(far_arg), .done_out(far_done), .locked_out(lk),
      .sense_out(sense), .ev_out(ev), .info_valid_out(iv), .info_crc_ok_out(iok),
      .info_sensor_out(isen), .long_packet_out(lp), .packet_bytes_out(pb), .line_valid_out(lv),
      .byte_valid_out(bv), .frame_end_out(fe));
   rx_link_status_monitor u_rx_link_status_monitor (.clk_sys_in(clk_sys_in),
      .resetn_in(resetn_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
      .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
      .port_locked_in(lk), .link_clk_sense_in(sense), .parity_err_in(ev[0]),
      .encoder_code_err_in(ev[1]), .encoder_seq_err_in(ev[2]), .ctrl_channel_crc_err_in(ev[3]),
      .ctrl_channel_seq_err_in(ev[4]), .info_valid_in(iv), .info_crc_ok_in(iok),
      .info_sensor_in(isen), .long_packet_in(lp), .packet_bytes_in(pb), .line_valid_in(lv),
      .byte_valid_in(bv), .frame_end_in(fe), .port_locked_out(locked_o), .irq_out(irq_o));
   initial begin
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   // The whole sequence needs about 1100 cycles, so this ceiling only trips on a hang.
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 30000) begin
         bad_count++;
         stop_test();
      end
   end
   // ****************************************
   // Bus and compare helpers
   // ****************************************
   task automatic stop_test();
      $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : stop_test
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys_in);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1'b1;
      @(negedge clk_sys_in);
      reg_wr_in = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_sys_in);
      reg_addr_in = a;
      reg_rd_in = 1'b1;
      @(negedge clk_sys_in);
      reg_rd_in = 1'b0;
      d = reg_rdata_out;
   endtask : rd
   task automatic chk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      logic [7:0] d;
      rd(a, d);
      cmp({8'h00, d & m}, {8'h00, e});
   endtask : chk
   task automatic chk16(input logic [7:0] a, input logic [15:0] e);
      logic [7:0] h;
      logic [7:0] l;
      rd(a, h);
      rd(a + 8'h01, l);
      cmp({h, l}, e);
   endtask : chk16
   task automatic sens(input logic [31:0] e);
      for (int i = 0; i < 4; i++) begin
         chk(ADDR_SENSOR_STATUS_A + 8'(i), e[8*i +: 8], 8'hFF);
      end
   endtask : sens
   task automatic wait_n(input int n);
      repeat (n) @(negedge clk_sys_in);
   endtask : wait_n
   task automatic far(input logic [2:0] c, input logic [31:0] a);
      wait (!far_done);
      @(posedge clk_sys_in);
      far_cmd = c;
      far_arg = a;
      wait (far_done);
      far_cmd = 3'h0;
   endtask : far
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      wait_n(10);
      resetn_in = 1'b1;
      chk(ADDR_GENERAL_CONFIG, GENERAL_CONFIG_RESET, 8'hFF);
      chk(ADDR_FREQ_DETECT_CONTROL, FREQ_DETECT_CONTROL_RESET, 8'hFF);
      chk(ADDR_ENCODER_CRC_CONTROL, ENCODER_CRC_CONTROL_RESET, 8'hFF);
      wr(ADDR_PARITY_COUNT_HIGH, 8'h5A);
      wr(8'hC0, 8'hFF);
      chk(ADDR_PARITY_COUNT_HIGH, 8'h00, 8'hFF);
      chk(8'hC0, 8'h00, 8'hFF);
      $display("test registers done");
      far(3'h1, 32'h1);
      wait_n(10);
      chk(ADDR_PORT_STATUS_ONE, 8'h03, 8'h37);
      far(3'h2, 32'h18);
      chk(ADDR_PORT_STATUS_ONE, 8'h31, 8'h37);
      chk(ADDR_PORT_STATUS_ONE, 8'h01, 8'h37);
      $display("test lock done");
      wr(ADDR_PARITY_THRESHOLD, 8'h03);
      repeat (3) far(3'h2, 32'h01);
      chk(ADDR_PORT_STATUS_ONE, 8'h05, 8'h37);
      wr(ADDR_GENERAL_CONFIG, 8'h00);
      far(3'h2, 32'h01);
      chk16(ADDR_PARITY_COUNT_HIGH, 16'h0003);
      chk(ADDR_PARITY_COUNT_HIGH, 8'h00, 8'hFF);
      chk(ADDR_PARITY_COUNT_HIGH, 8'h00, 8'hFF);
      chk(ADDR_PORT_STATUS_ONE, 8'h01, 8'h37);
      wr(ADDR_GENERAL_CONFIG, 8'h01);
      repeat (2) far(3'h2, 32'h01);
      far(3'h1, 32'h0);
      wait_n(10);
      far(3'h1, 32'h1);
      wait_n(10);
      chk16(ADDR_PARITY_COUNT_HIGH, 16'h0000);
      chk(ADDR_PORT_STATUS_ONE, 8'h03, 8'h37);
      $display("test parity done");
      far(3'h2, 32'h02);
      chk(ADDR_PORT_STATUS_TWO, 8'h20, 8'h20);
      chk(ADDR_PORT_STATUS_TWO, 8'h00, 8'h20);
      far(3'h2, 32'h04);
      chk(ADDR_PORT_STATUS_TWO, 8'h20, 8'h20);
      $display("test encoder done");
      far(3'h3, 32'h11223344);
      sens(32'h11223344);
      wr(ADDR_PORT_CAPABILITY, 8'h10);
      wr(ADDR_ENCODER_CRC_CONTROL, 8'h00);
      far(3'h3, 32'h55667788);
      sens(32'h11223344);
      far(3'h4, 32'h99AABBCC);
      sens(32'h99AABBCC);
      chk(ADDR_SENSOR_RISE_IRQ, 8'hCC, 8'hFF);
      chk(ADDR_SENSOR_RISE_IRQ, 8'h00, 8'hFF);
      $display("test sensor done");
      far(3'h1, 32'h3);
      wait_n(400);
      chk16(ADDR_FREQ_VALUE_HIGH, 16'h000A);
      chk(ADDR_PORT_STATUS_TWO, 8'h02, 8'h06);
      far(3'h1, 32'h1);
      wait_n(400);
      chk(ADDR_PORT_STATUS_TWO, 8'h04, 8'h06);
      chk16(ADDR_FREQ_VALUE_HIGH, 16'h0000);
      $display("test frequency done");
      far(3'h5, 32'h0100);
      far(3'h5, 32'h0456);
      far(3'h6, 32'h0);
      chk16(ADDR_LINES_HIGH, 16'h0002);
      chk16(ADDR_LINE_BYTES_HIGH, 16'h0456);
      wr(ADDR_GENERAL_CONFIG, 8'h03);
      wr(ADDR_IRQ_ENABLE, 8'h08);
      far(3'h6, 32'h5);
      far(3'h6, 32'h0);
      wait_n(2);
      cmp({15'h0000, irq_o}, 16'h0001);
      far(3'h6, 32'h3);
      far(3'h6, 32'h3);
      far(3'h6, 32'h0);
      chk16(ADDR_LINES_HIGH, 16'h0001);
      chk16(ADDR_LINE_BYTES_HIGH, 16'h0003);
      cmp({15'h0000, irq_o}, 16'h0000);
      $display("test lines done");
      stop_test();
   end
endmodule : tb_top
